// ### design/sam_alarm_manager.sv
// servo alarm manager: fault detect, latch, code outputs and history
`timescale 1ns/1ps
module sam_alarm_manager
   import sam_pkg::*;
#(
   parameter int OL_TICK_CYC = SAM_OL_TICK_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire sam_det_t    det_i,
   input  wire sam_enc_t    enc_i,
   input  wire sam_param_t  param_i,
   input  wire logic [23:0] deviation_count_i,
   input  wire logic        run_i,
   input  wire logic        fault_reset_i,
   input  wire logic        power_up_i,
   input  wire logic        panel_reset_i,
   input  wire logic        panel_confirm_i,
   input  wire logic        panel_no_link_i,
   input  wire logic        panel_timeout_i,
   input  wire logic        nv_overcurrent_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_write_i,
   input  wire logic        reg_read_i,
   output logic [31:0]      reg_rdata_o,
   output logic             fault_flag_out_o,
   output logic             fault_code_bit1_o,
   output logic             fault_code_bit2_o,
   output logic             fault_code_bit3_o,
   output logic [7:0]       fault_disp_o,
   output logic             power_enable_o,
   output logic             nv_overcurrent_o,
   output logic             panel_no_link_o,
   output logic             panel_timeout_o
);
   typedef enum logic [1:0] {
      ST_OK    = 2'b00,
      ST_FAULT = 2'b01,
      ST_CLEAR = 2'b11
   } sam_state_t;
   sam_state_t  state_q;
   logic [2:0]  code_q;
   logic [7:0]  disp_q;
   logic [23:0] devlim_q;
   logic [7:0]  syschk_q;
   logic [3:0]  histsel_q;
   logic [15:0] setup_q;
   logic [7:0]  hist_q [SAM_HIST_DEPTH];
   logic [3:0]  hcount_q;
   logic [15:0] psum_q;
   logic        param_bad_q;
   logic [23:0] ol_acc_q;
   logic [16:0] ol_tick_q;
   logic        adc_busy_q;
   logic [11:0] adc_cnt_q;
   logic        adc_to_q;
   logic [4:0]  enc_cnt_q [3];
   logic [2:0]  enc_bad;
   logic        nv_pending_q;
   logic        oc_nv_q;
   logic        any_fault;
   logic [2:0]  new_code;
   logic [7:0]  new_disp;
   logic        clear_req;
   logic        hist_push;
   logic [7:0]  hist_val;
   logic        ol_tick;
   logic [9:0]  ol_excess;
   // parameter checksum accumulated over the load stream
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         psum_q      <= 16'h0000;
         param_bad_q <= 1'b0;
      end else if (param_i.valid) begin
         if (param_i.last) begin
            psum_q      <= 16'h0000;
            param_bad_q <= (psum_q + param_i.word) != param_i.expect_sum;
         end else begin
            psum_q      <= psum_q + param_i.word;
            param_bad_q <= 1'b0;
         end
      end else begin
         param_bad_q <= 1'b0;
      end
   end
   // electronic thermal: excess-percent integrated each millisecond
   assign ol_tick   = (ol_tick_q == 17'(OL_TICK_CYC - 1));
   assign ol_excess = (det_i.load_pct > SAM_OL_RATED) ?
                      det_i.load_pct - SAM_OL_RATED : 10'h000;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ol_tick_q <= 17'h00000;
         ol_acc_q  <= 24'h000000;
      end else begin
         ol_tick_q <= ol_tick ? 17'h00000 : ol_tick_q + 17'h00001;
         if (ol_tick) begin
            if (det_i.load_pct >= SAM_OL_START) begin
               ol_acc_q <= ol_acc_q + {14'h0000, ol_excess};
            end else if (ol_acc_q != 24'h000000) begin
               ol_acc_q <= ol_acc_q - 24'h000001; // slow cooling
            end
         end
      end
   end
   // converter timeout between start and done
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         adc_busy_q <= 1'b0;
         adc_cnt_q  <= 12'h000;
         adc_to_q   <= 1'b0;
      end else begin
         adc_to_q <= 1'b0;
         if (det_i.adc_done) begin
            adc_busy_q <= 1'b0;
         end else if (det_i.adc_start) begin
            adc_busy_q <= 1'b1;
            adc_cnt_q  <= 12'h000;
         end else if (adc_busy_q) begin
            adc_cnt_q <= adc_cnt_q + 12'h001;
            if (adc_cnt_q == SAM_ADC_TO_CYC - 12'h001) begin
               adc_to_q   <= 1'b1;
               adc_busy_q <= 1'b0;
            end
         end
      end
   end
   // encoder pairs equal for a while mean open or shorted line
   generate
      for (genvar g = 0; g < 3; g++) begin : g_enc
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               enc_cnt_q[g] <= 5'h00;
            end else if (enc_i.pos[g] != enc_i.neg[g]) begin
               enc_cnt_q[g] <= 5'h00;
            end else if (enc_cnt_q[g] != SAM_ENC_BAD_CYC) begin
               enc_cnt_q[g] <= enc_cnt_q[g] + 5'h01;
            end
         end
         assign enc_bad[g] = (enc_cnt_q[g] == SAM_ENC_BAD_CYC);
      end
   endgenerate
   // fault priority encoder
   always_comb begin
      any_fault = 1'b1;
      new_code  = SAM_C_NONE;
      new_disp  = SAM_D_ABS;
      if (det_i.overcurrent || (nv_pending_q && nv_overcurrent_i)) begin
         new_code = SAM_C_OC;
         new_disp = SAM_D_OC;
      end else if (det_i.sensor_on_request && det_i.abs_valid &&
                   det_i.abs_err) begin
         new_code = SAM_C_NONE;
         new_disp = SAM_D_ABS;
      end else if (param_bad_q) begin
         new_code = SAM_C_NONE;
         new_disp = SAM_D_PARAM;
      end else if (deviation_count_i > devlim_q) begin
         new_code = SAM_C_DEV;
         new_disp = SAM_D_DEV;
      end else if (det_i.vbus_volts < SAM_VBUS_MIN ||
                   det_i.vbus_volts > SAM_VBUS_MAX) begin
         new_code = SAM_C_VOLT;
         new_disp = SAM_D_VOLT;
      end else if (ol_acc_q >= SAM_OL_TRIP) begin
         new_code = SAM_C_OL;
         new_disp = (det_i.load_pct > SAM_OL_INST) ? SAM_D_OLI : SAM_D_OLS;
      end else if (adc_to_q) begin
         new_code = SAM_C_NONE;
         new_disp = SAM_D_ADC;
      end else if (enc_bad[0] || enc_bad[1]) begin
         new_code = SAM_C_ENC;
         new_disp = SAM_D_ENCAB;
      end else if (enc_bad[2]) begin
         new_code = SAM_C_ENC;
         new_disp = SAM_D_ENCZ;
      end else if (det_i.phase_loss) begin
         new_code = SAM_C_PHASE;
         new_disp = SAM_D_PHASE;
      end else begin
         any_fault = 1'b0;
      end
   end
   // overcurrent kept across power cycles is restored after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nv_pending_q <= 1'b1;
      end else begin
         nv_pending_q <= 1'b0;
      end
   end
   // clear request; power-up alone never clears overcurrent
   assign clear_req = fault_reset_i || panel_reset_i ||
                      (power_up_i && disp_q != SAM_D_OC);
   // fault latch state machine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_OK;
         code_q  <= SAM_C_NONE;
         disp_q  <= SAM_D_RESET;
         oc_nv_q <= 1'b0;
      end else begin
         case (state_q)
            ST_OK: begin
               if (nv_pending_q && nv_overcurrent_i) begin
                  state_q <= ST_FAULT;
                  code_q  <= SAM_C_OC;
                  disp_q  <= SAM_D_OC;
                  oc_nv_q <= 1'b1;
               end else if (any_fault && !nv_pending_q) begin
                  state_q <= ST_FAULT;
                  code_q  <= new_code;
                  disp_q  <= new_disp;
                  oc_nv_q <= (new_disp == SAM_D_OC);
               end
            end
            ST_FAULT: begin
               if (clear_req) begin
                  state_q <= ST_CLEAR;
               end
            end
            ST_CLEAR: begin
               state_q <= ST_OK;
               code_q  <= SAM_C_NONE;
               disp_q  <= SAM_D_RESET;
               oc_nv_q <= 1'b0;
            end
            default: state_q <= ST_OK;
         endcase
      end
   end
   // history entry on each new fault and on each reset
   assign hist_push = (state_q == ST_OK && !nv_pending_q && any_fault) ||
                      (state_q == ST_CLEAR) ||
                      (state_q == ST_OK && power_up_i);
   assign hist_val  = (state_q == ST_OK && any_fault) ? new_disp :
                      SAM_D_RESET;
   // history shift register, newest at index zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hcount_q <= 4'h0;
         for (int i = 0; i < SAM_HIST_DEPTH; i++) begin
            hist_q[i] <= 8'h00;
         end
      end else if (panel_confirm_i &&
                   syschk_q == SAM_SYSCHK_CLRHIST) begin
         hcount_q <= 4'h0;
         for (int i = 0; i < SAM_HIST_DEPTH; i++) begin
            hist_q[i] <= 8'h00;
         end
      end else if (hist_push) begin
         hist_q[0] <= hist_val;
         for (int i = 1; i < SAM_HIST_DEPTH; i++) begin
            hist_q[i] <= hist_q[i-1];
         end
         if (hcount_q != 4'(SAM_HIST_DEPTH)) begin
            hcount_q <= hcount_q + 4'h1;
         end
      end
   end
   // register writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         devlim_q  <= SAM_RST_DEVLIM;
         syschk_q  <= SAM_RST_SYSCHK;
         histsel_q <= 4'h0;
         setup_q   <= SAM_RST_SETUP;
      end else if (reg_write_i) begin
         case (reg_addr_i)
            SAM_OFS_DEVLIM:  devlim_q  <= reg_wdata_i[23:0];
            SAM_OFS_SYSCHK:  syschk_q  <= reg_wdata_i[7:0];
            SAM_OFS_HISTSEL: histsel_q <= reg_wdata_i[3:0];
            SAM_OFS_SETUP:   setup_q   <= reg_wdata_i[15:0];
            default: ;
         endcase
      end
   end
   // register reads, data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_i) begin
      reg_rdata_o <= 32'h00000000;
      if (!rst_i && reg_read_i) begin
         case (reg_addr_i)
            SAM_OFS_STATUS: begin
               reg_rdata_o[SAM_ST_ACTIVE_BIT]        <= state_q != ST_OK;
               reg_rdata_o[SAM_ST_CODE_LSB +: 3]     <= code_q;
               reg_rdata_o[SAM_ST_DISP_LSB +: 8]     <= disp_q;
               reg_rdata_o[SAM_ST_NOLINK_BIT]        <= panel_no_link_o;
               reg_rdata_o[SAM_ST_PTO_BIT]           <= panel_timeout_o;
               reg_rdata_o[SAM_ST_PWR_BIT]           <= power_enable_o;
            end
            SAM_OFS_DEVLIM:   reg_rdata_o[23:0] <= devlim_q;
            SAM_OFS_SYSCHK:   reg_rdata_o[7:0]  <= syschk_q;
            SAM_OFS_HISTSEL:  reg_rdata_o[7:0]  <= {hcount_q, histsel_q};
            SAM_OFS_HISTDATA: reg_rdata_o[7:0]  <=
               (histsel_q < hcount_q && histsel_q <= SAM_HIST_LAST) ?
               hist_q[histsel_q] : 8'h00;
            SAM_OFS_SETUP:    reg_rdata_o[15:0] <= setup_q;
            default:          reg_rdata_o <= 32'h00000000;
         endcase
      end
   end
   // panel link errors, flags only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         panel_no_link_o <= 1'b0;
         panel_timeout_o <= 1'b0;
      end else begin
         panel_no_link_o <= panel_no_link_i;
         panel_timeout_o <= panel_timeout_i;
      end
   end
   // fault outputs; flag high means output stage conducting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_flag_out_o <= 1'b0;
         power_enable_o   <= 1'b0;
      end else begin
         fault_flag_out_o <= (state_q == ST_OK) && !any_fault;
         power_enable_o   <= (state_q == ST_OK) && !any_fault &&
            (run_i || setup_q[SAM_SETUP_SRVON_BIT]);
      end
   end
   assign fault_code_bit1_o = code_q[0];
   assign fault_code_bit2_o = code_q[1];
   assign fault_code_bit3_o = code_q[2];
   assign fault_disp_o      = disp_q;
   assign nv_overcurrent_o  = oc_nv_q;
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_FLAG_OFF_ON_FAULT: assert property (
      state_q == ST_FAULT |=> !fault_flag_out_o && !power_enable_o)
      else $error("flag or power on while faulted");
   AST_FLAG_HEALTHY: assert property (
      state_q == ST_OK && !any_fault && !nv_pending_q |=> fault_flag_out_o)
      else $error("flag not conducting while healthy");
   AST_DEV_CODE: assert property (
      state_q == ST_OK && !nv_pending_q && new_disp == SAM_D_DEV &&
      any_fault |=> code_q == 3'h3 && disp_q == SAM_D_DEV)
      else $error("deviation code wrong");
   AST_VOLT_CODE: assert property (
      state_q == ST_OK && !nv_pending_q && new_disp == SAM_D_VOLT &&
      any_fault |=> code_q == 3'h4)
      else $error("voltage code wrong");
   AST_LATCH_HOLD: assert property (
      state_q == ST_FAULT && !clear_req |=> state_q == ST_FAULT &&
      $stable(code_q) && $stable(disp_q))
      else $error("fault not held");
   AST_OC_POWERUP: assert property (
      state_q == ST_FAULT && disp_q == SAM_D_OC && power_up_i &&
      !fault_reset_i && !panel_reset_i |=> state_q == ST_FAULT)
      else $error("overcurrent cleared by power-up");
   AST_CLEAR_TWO: assert property (
      state_q == ST_FAULT && fault_reset_i |=> ##1 state_q == ST_OK)
      else $error("reset input did not clear fault");
   AST_MARKER: assert property (
      state_q == ST_CLEAR && !(panel_confirm_i &&
      syschk_q == SAM_SYSCHK_CLRHIST) |=> hist_q[0] == SAM_D_RESET)
      else $error("reset marker missing");
   AST_SHIFT: assert property (
      hist_push && !(panel_confirm_i && syschk_q == SAM_SYSCHK_CLRHIST)
      |=> hist_q[SAM_HIST_LAST] == $past(hist_q[SAM_HIST_LAST - 4'h1]))
      else $error("history not shifted");
   AST_ERASE: assert property (
      panel_confirm_i && syschk_q == SAM_SYSCHK_CLRHIST |=>
      hcount_q == 4'h0)
      else $error("history not erased");
endmodule : sam_alarm_manager

// ### design/sam_pkg.sv
// package of constants and types for the servo alarm manager
package sam_pkg;
   // register offsets (byte addresses)
   localparam logic [7:0] SAM_OFS_STATUS   = 8'h00;
   localparam logic [7:0] SAM_OFS_DEVLIM   = 8'h04;
   localparam logic [7:0] SAM_OFS_SYSCHK   = 8'h08;
   localparam logic [7:0] SAM_OFS_HISTSEL  = 8'h0C;
   localparam logic [7:0] SAM_OFS_HISTDATA = 8'h10;
   localparam logic [7:0] SAM_OFS_SETUP    = 8'h14;
   // reset values
   localparam logic [23:0] SAM_RST_DEVLIM  = 24'h002800;
   localparam logic [7:0]  SAM_RST_SYSCHK  = 8'h00;
   localparam logic [15:0] SAM_RST_SETUP   = 16'h0000;
   // field positions
   localparam int SAM_SETUP_SRVON_BIT = 0;
   localparam int SAM_ST_ACTIVE_BIT   = 0;
   localparam int SAM_ST_CODE_LSB     = 1;
   localparam int SAM_ST_DISP_LSB     = 4;
   localparam int SAM_ST_NOLINK_BIT   = 12;
   localparam int SAM_ST_PTO_BIT      = 13;
   localparam int SAM_ST_PWR_BIT      = 14;
   // system check value that erases the history
   localparam logic [7:0] SAM_SYSCHK_CLRHIST = 8'h02;
   // history
   localparam int          SAM_HIST_DEPTH = 10;
   localparam logic [3:0]  SAM_HIST_LAST  = 4'h9;
   // display codes
   localparam logic [7:0] SAM_D_ABS   = 8'h00;
   localparam logic [7:0] SAM_D_PARAM = 8'h02;
   localparam logic [7:0] SAM_D_OC    = 8'h10;
   localparam logic [7:0] SAM_D_DEV   = 8'h31;
   localparam logic [7:0] SAM_D_VOLT  = 8'h40;
   localparam logic [7:0] SAM_D_OLI   = 8'h71;
   localparam logic [7:0] SAM_D_OLS   = 8'h72;
   localparam logic [7:0] SAM_D_ADC   = 8'hB1;
   localparam logic [7:0] SAM_D_ENCAB = 8'hC3;
   localparam logic [7:0] SAM_D_ENCZ  = 8'hC4;
   localparam logic [7:0] SAM_D_PHASE = 8'hF1;
   localparam logic [7:0] SAM_D_RESET = 8'h99;
   // three-bit codes, bit1 in lsb
   localparam logic [2:0] SAM_C_NONE  = 3'h0;
   localparam logic [2:0] SAM_C_OC    = 3'h1;
   localparam logic [2:0] SAM_C_DEV   = 3'h3;
   localparam logic [2:0] SAM_C_VOLT  = 3'h4;
   localparam logic [2:0] SAM_C_OL    = 3'h7;
   localparam logic [2:0] SAM_C_ENC   = 3'h5;
   localparam logic [2:0] SAM_C_PHASE = 3'h2;
   // limits
   localparam logic [9:0] SAM_VBUS_MIN   = 10'd150;
   localparam logic [9:0] SAM_VBUS_MAX   = 10'd420;
   localparam logic [9:0] SAM_OL_START   = 10'd120;
   localparam logic [9:0] SAM_OL_INST    = 10'd135;
   localparam logic [9:0] SAM_OL_RATED   = 10'd100;
   // 300 % held 3000 ms gives 200*3000 of excess-percent milliseconds
   localparam logic [23:0] SAM_OL_TRIP   = 24'd600000;
   localparam int  SAM_CLK_MHZ           = 125;
   localparam int  SAM_OL_TICK_US        = 1000;
   localparam int  SAM_OL_TICK_CYC       = SAM_OL_TICK_US * SAM_CLK_MHZ;
   localparam int  SAM_ADC_TO_US         = 10;
   localparam logic [11:0] SAM_ADC_TO_CYC =
      12'(SAM_ADC_TO_US * SAM_CLK_MHZ);
   localparam logic [4:0] SAM_ENC_BAD_CYC = 5'd16;
   // detector inputs
   typedef struct packed {
      logic       overcurrent;
      logic       sensor_on_request;
      logic       abs_valid;
      logic       abs_err;
      logic       phase_loss;
      logic [9:0] vbus_volts;
      logic [9:0] load_pct;
      logic       adc_start;
      logic       adc_done;
   } sam_det_t;
   // differential encoder lines a, b, z
   typedef struct packed {
      logic [2:0] pos;
      logic [2:0] neg;
   } sam_enc_t;
   // parameter load stream
   typedef struct packed {
      logic        valid;
      logic        last;
      logic [15:0] word;
      logic [15:0] expect_sum;
   } sam_param_t;
endpackage : sam_pkg

// ### verification/sam_alarm_manager_tb.sv
// self-checking bench of the servo alarm manager
`timescale 1ns/1ps
module sam_alarm_manager_tb;
   import sam_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   sam_det_t det;
   sam_enc_t enc;
   sam_param_t prm;
   logic [23:0] dev;
   logic pnl, pto, fl, pw, c1, c2, c3, nvo, nlo, too;
   logic [7:0] disp, addr;
   logic [31:0] rdata, wdata, d, r;
   logic wr, rd, run, fres, pres, pup, conf, nvi;
   int n_fail = 0;
   int cmp_count = 0;
   // free-running 125 MHz clock
   always #4 clk_i = ~clk_i;
   sam_host_model host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .run_o(run), .fres_o(fres),
      .pres_o(pres), .pup_o(pup), .conf_o(conf));
   sam_alarm_manager #(.OL_TICK_CYC(10)) uut (.clk_i(clk_i), .rst_i(rst_i),
      .det_i(det), .enc_i(enc), .param_i(prm), .deviation_count_i(dev),
      .run_i(run), .fault_reset_i(fres), .power_up_i(pup),
      .panel_reset_i(pres), .panel_confirm_i(conf), .panel_no_link_i(pnl),
      .panel_timeout_i(pto), .nv_overcurrent_i(nvi), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd),
      .reg_rdata_o(rdata), .fault_flag_out_o(fl), .fault_code_bit1_o(c1),
      .fault_code_bit2_o(c2), .fault_code_bit3_o(c3), .fault_disp_o(disp),
      .power_enable_o(pw), .nv_overcurrent_o(nvo), .panel_no_link_o(nlo),
      .panel_timeout_o(too));
   // pseudo-random source
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // expected display code and three-bit code per fault kind
   function automatic logic [10:0] exp_out(input int k);
      case (k)
         0: return {SAM_D_OC, SAM_C_OC};
         1: return {SAM_D_ABS, SAM_C_NONE};
         2: return {SAM_D_PARAM, SAM_C_NONE};
         3: return {SAM_D_DEV, SAM_C_DEV};
         4: return {SAM_D_VOLT, SAM_C_VOLT};
         5: return {SAM_D_ADC, SAM_C_NONE};
         6: return {SAM_D_ENCAB, SAM_C_ENC};
         7: return {SAM_D_ENCZ, SAM_C_ENC};
         8: return {SAM_D_PHASE, SAM_C_PHASE};
         default: return {SAM_D_OLI, SAM_C_OL};
      endcase
   endfunction : exp_out
   task automatic chk(input logic [31:0] g, e, input string m);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic tally_and_finish();
      if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   // bounded wait on the fault flag
   task automatic wait_flag(input logic v, input int lim);
      for (int i = 0; i < lim && fl !== v; i++) @(posedge clk_i);
      if (fl !== v) begin
         n_fail++;
         $display("wrong value at %0t: flag wait", $time);
         tally_and_finish();
      end
   endtask : wait_flag
   // all detectors healthy
   task automatic heal();
      det <= {5'h00, 10'h12C, 10'h032, 2'h0};
      enc <= {3'h5, 3'h2};
      prm <= '0;
      dev <= '0;
   endtask : heal
   task automatic inject(input int k);
      @(posedge clk_i);
      case (k)
         0: det.overcurrent <= 1'b1;
         1: {det.sensor_on_request, det.abs_valid, det.abs_err} <= 3'h7;
         2: prm <= {2'h3, r[15:0], r[15:0] + 16'h0001};
         3: dev <= SAM_RST_DEVLIM + 24'h000001 + r[7:0];
         4: det.vbus_volts <= r[0] ? 10'h095 : 10'h1A5;
         5: det.adc_start <= 1'b1;
         6: enc <= {3'h5, 3'h3};
         7: enc <= {3'h5, 3'h6};
         8: det.phase_loss <= 1'b1;
         default: det.load_pct <= 10'h12C;
      endcase
      @(posedge clk_i);
      det.adc_start <= 1'b0;
      prm.valid <= 1'b0;
   endtask : inject
   // main sequence
   initial begin
      r = 32'h6397;
      {pnl, pto, nvi} = 3'h0;
      heal();
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk({fl, pw, c3, c2, c1, disp}, {5'h18, 8'h99}, "after reset");
      host.rd(SAM_OFS_DEVLIM, d);
      chk(d, {8'h00, SAM_RST_DEVLIM}, "devlim reset");
      host.wr(8'hFC, r);
      host.rd(8'hFC, d);
      chk(d, 32'h0, "unmapped");
      for (int k = 0; k < 10; k++) begin
         r = lfsr(r);
         inject(k);
         if (k == 9) begin
            repeat (29000) @(posedge clk_i);
            chk(fl, 1'b1, "early overload");
         end
         wait_flag(1'b0, 2000);
         heal();
         repeat (3) @(posedge clk_i);
         chk({fl, pw, disp, c3, c2, c1}, {2'h0, exp_out(k)}, "fault");
         host.rd(SAM_OFS_STATUS, d);
         chk(d[11:0], {exp_out(k), 1'b1}, "status");
         host.wr(SAM_OFS_STATUS, 32'h0);
         host.rd(SAM_OFS_STATUS, d);
         chk(d[0], 1'b1, "status read-only");
         host.wr(SAM_OFS_HISTSEL, 32'h0);
         host.rd(SAM_OFS_HISTDATA, d);
         chk(d[7:0], exp_out(k) >> 3, "newest entry");
         host.wr(SAM_OFS_HISTSEL, 32'h1);
         host.rd(SAM_OFS_HISTDATA, d);
         if (k > 0) chk(d[7:0], SAM_D_RESET, "older entry");
         if (k == 0) begin
            host.clr(2);
            repeat (3) @(posedge clk_i);
            chk({fl, nvo, c1}, 3'h3, "overcurrent kept");
            // full power cycle: stored overcurrent comes back after reset
            nvi <= nvo;
            rst_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            repeat (3) @(posedge clk_i);
            chk({fl, pw, nvo, c1, disp}, {4'h3, SAM_D_OC}, "oc restored");
            nvi <= 1'b0;
         end
         host.clr(k % 3);
         repeat (4) @(posedge clk_i);
         if (k < 9) chk({fl, pw, c3, c2, c1, disp}, 13'h1899, "clear");
         host.wr(SAM_OFS_HISTSEL, 32'h0);
         host.rd(SAM_OFS_HISTDATA, d);
         chk(d[7:0], SAM_D_RESET, "marker");
      end
      host.rd(SAM_OFS_HISTSEL, d);
      chk(d[7:4], 4'hA, "full history");
      host.conf();
      host.rd(SAM_OFS_HISTSEL, d);
      chk(d[7:4], 4'hA, "confirm alone");
      host.wr(SAM_OFS_SYSCHK, {24'h0, SAM_SYSCHK_CLRHIST});
      host.conf();
      host.rd(SAM_OFS_HISTSEL, d);
      chk(d[7:4], 4'h0, "history erased");
      @(posedge clk_i);
      {pnl, pto} <= 2'h3;
      repeat (3) @(posedge clk_i);
      chk({nlo, too}, 2'h3, "panel errors");
      host.rd(SAM_OFS_HISTSEL, d);
      chk(d[7:4], 4'h0, "panel not stored");
      // run dropped stops the drive, servo-always-on brings it back
      host.run(1'b0);
      repeat (3) @(posedge clk_i);
      chk(pw, 1'b0, "run off");
      host.wr(SAM_OFS_SETUP, 32'h1);
      repeat (3) @(posedge clk_i);
      chk(pw, 1'b1, "servo always on");
      host.rd(SAM_OFS_SETUP, d);
      chk(d, 32'h1, "setup readback");
      tally_and_finish();
   end
endmodule : sam_alarm_manager_tb

// ### verification/sam_host_model.sv
// host controller and panel model: register master and clear actions
`timescale 1ns/1ps
module sam_host_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] rdata_i,
   output logic [7:0]       addr_o,
   output logic [31:0]      wdata_o,
   output logic             wr_o,
   output logic             rd_o,
   output logic             run_o,
   output logic             fres_o,
   output logic             pres_o,
   output logic             pup_o,
   output logic             conf_o
);
   // idle bus, run command left on to show resume at clear
   initial begin
      {addr_o, wdata_o, wr_o, rd_o, fres_o, pres_o, pup_o, conf_o} = '0;
      run_o = 1'b1;
   end
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
   endtask : wr
   // one-cycle read strobe, data taken in the cycle after
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      @(negedge clk_i);
      d = rdata_i;
   endtask : rd
   // clear by reset input, panel reset or power cycle
   task automatic clr(input int m);
      @(posedge clk_i);
      fres_o <= (m == 0);
      pres_o <= (m == 1);
      pup_o  <= (m == 2);
      @(posedge clk_i);
      {fres_o, pres_o, pup_o} <= 3'h0;
   endtask : clr
   // run command level change
   task automatic run(input logic v);
      @(posedge clk_i);
      run_o <= v;
   endtask : run
   // panel confirm key press
   task automatic conf();
      @(posedge clk_i);
      conf_o <= 1'b1;
      @(posedge clk_i);
      conf_o <= 1'b0;
   endtask : conf
endmodule : sam_host_model
